// file: mssr_pkg.sv
`default_nettype none
package mssr_pkg;
   // Register byte offsets on the APB side.
   localparam logic [15:0] OFS_MODE = 16'h251C;
   localparam logic [15:0] OFS_TOTAL_LO = 16'h2710;
   localparam logic [15:0] OFS_TOTAL_HI = 16'h2714;
   localparam logic [15:0] OFS_LOOPS = 16'h2724;
   localparam logic [15:0] OFS_SEGLEN = 16'h2730;
   localparam logic [15:0] OFS_CHAN = 16'h2734;
   localparam logic [15:0] OFS_CTRL = 16'h2740;
   localparam logic [15:0] OFS_STATUS = 16'h2744;
   localparam logic [15:0] OFS_SEGCNT = 16'h2748;
   localparam int unsigned APB_AW = 16;
   localparam int unsigned APB_DW = 32;
   // Operating mode codes.
   localparam logic [31:0] STD_MULTI_CODE = 32'h0000_0200;
   localparam logic [31:0] STRM_MULTI_CODE = 32'h0000_1000;
   // Control and status bit positions.
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_STOP_BIT = 1;
   localparam int unsigned STAT_RUN_BIT = 0;
   localparam int unsigned STAT_ARMED_BIT = 1;
   localparam int unsigned STAT_ERR_BIT = 2;
   localparam int unsigned STAT_DATA_BIT = 3;
   localparam int unsigned CHAN_W = 2;
   // Sample storage.
   localparam int unsigned SAMPLE_BYTES = 2;
   localparam int unsigned SAMPLE_W = 8 * SAMPLE_BYTES;
   localparam int unsigned CNT_W = 64;
   localparam int unsigned SEG_W = 32;
   localparam int unsigned LOOP_W = 32;
   localparam int unsigned FIFO_DEPTH = 8;
   // Reset values.
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [63:0] TOTAL_RST = 64'h0000_0000_0000_0010;
   localparam logic [31:0] LOOPS_RST = 32'h0000_0001;
   localparam logic [31:0] SEGLEN_RST = 32'h0000_0008;
   localparam logic [1:0] CHAN_RST = 2'h0;
   typedef enum logic [1:0] {MSSR_IDLE, MSSR_ARMED, MSSR_PLAY} mssr_state_t;
endpackage
`default_nettype wire

// file: mssr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module mssr_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_r != FULL_CNT);
   assign out_valid_o = (cnt_r != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_r[rptr_r];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_r[wptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wptr_r <= (wptr_r == LAST_PTR) ? '0 : wptr_r + 1'b1;
         end
         if (pop)
         begin
            rptr_r <= (rptr_r == LAST_PTR) ? '0 : rptr_r + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_r <= cnt_r + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // mssr_fifo
`default_nettype wire

// file: mssr_top.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mssr_top #(
   parameter int unsigned MEM_AW = 32,
   parameter logic [63:0] MEM_SAMPLES = 64'h0000_0000_2000_0000,
   parameter int unsigned BUF_DEPTH = mssr_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [mssr_pkg::APB_AW-1:0] paddr_i,
   input wire logic [mssr_pkg::APB_DW-1:0] pwdata_i,
   output logic [mssr_pkg::APB_DW-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic trigger_i,
   input wire logic [mssr_pkg::SAMPLE_W-1:0] strm_data_i,
   input wire logic strm_valid_i,
   output logic strm_ready_o,
   output logic mem_rd_o,
   output logic [MEM_AW-1:0] mem_addr_o,
   input wire logic [mssr_pkg::SAMPLE_W-1:0] mem_rdata_i,
   output logic [mssr_pkg::SAMPLE_W-1:0] sample_o,
   output logic sample_valid_o,
   output logic armed_o
);
   import mssr_pkg::*;

   logic [31:0] mode_r;
   logic [CNT_W-1:0] total_r;
   logic [LOOP_W-1:0] loops_r;
   logic [SEG_W-1:0] seglen_r;
   logic [CHAN_W-1:0] chan_r;
   mssr_state_t state_r;
   logic [CNT_W-1:0] seg_base_r;
   logic [SEG_W-1:0] idx_r;
   logic [LOOP_W-1:0] segs_r;
   logic err_r;
   logic trig_s1_r;
   logic trig_s2_r;
   logic trig_s3_r;
   logic rd_r;
   logic rd_lat_r;
   logic [MEM_AW-1:0] mem_addr_r;
   logic [SAMPLE_W-1:0] sample_r;
   logic svalid_r;
   logic [APB_DW-1:0] prdata_r;
   logic [APB_DW-1:0] rdata_nxt;
   logic hit;
   logic apb_wr;
   logic start_req;
   logic stop_req;
   logic is_std;
   logic is_strm;
   logic cfg_bad;
   logic [CNT_W-1:0] mem_limit;
   logic trig_edge;
   logic fifo_valid;
   logic fifo_take;
   logic [SAMPLE_W-1:0] fifo_data;
   logic step;
   logic seg_end;
   logic [CNT_W-1:0] next_base;
   logic [CNT_W-1:0] rd_addr;
   logic mem_end;
   logic strm_done;

   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign start_req = apb_wr && (paddr_i == OFS_CTRL) &&
                      pwdata_i[CTRL_START_BIT];
   assign stop_req = apb_wr && (paddr_i == OFS_CTRL) &&
                     pwdata_i[CTRL_STOP_BIT];
   assign is_std = (mode_r == STD_MULTI_CODE);
   assign is_strm = (mode_r == STRM_MULTI_CODE);

   // The limit counts samples, and the memory share halves for each step of the channel setting.
   assign mem_limit = MEM_SAMPLES >> chan_r;
   assign cfg_bad = (!is_std && !is_strm) || (seglen_r == '0) ||
                    (is_std && (total_r > mem_limit));

   // The second and third synchroniser stages feed the edge detector.
   assign trig_edge = trig_s2_r & ~trig_s3_r;

   // The FIFO drains only while a segment plays, so the host is stalled once it fills between segments.
   assign fifo_take = (state_r == MSSR_PLAY) && is_strm;
   assign step = (state_r == MSSR_PLAY) && (is_std || fifo_valid);
   assign seg_end = step && (idx_r == seglen_r - 1'b1);
   assign next_base = seg_base_r + {{(CNT_W-SEG_W){1'b0}}, seglen_r};
   assign rd_addr = seg_base_r + {{(CNT_W-SEG_W){1'b0}}, idx_r};
   assign mem_end = (next_base >= total_r);
   // The segment that is ending now already counts towards the total.
   assign strm_done = (loops_r != '0) && (segs_r + 1'b1 == loops_r);

   mssr_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(strm_valid_i),
      .in_ready_o(strm_ready_o),
      .in_data_i(strm_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_take),
      .out_data_o(fifo_data)
   );

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         trig_s3_r <= 1'b0;
      end
      else
      begin
         trig_s1_r <= trigger_i;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_r <= MODE_RST;
         total_r <= TOTAL_RST;
         loops_r <= LOOPS_RST;
         seglen_r <= SEGLEN_RST;
         chan_r <= CHAN_RST;
      end
      else if (apb_wr)
      begin
         case (paddr_i)
            OFS_MODE: mode_r <= pwdata_i;
            OFS_TOTAL_LO: total_r[31:0] <= pwdata_i;
            OFS_TOTAL_HI: total_r[63:32] <= pwdata_i;
            OFS_LOOPS: loops_r <= pwdata_i;
            OFS_SEGLEN: seglen_r <= pwdata_i;
            OFS_CHAN: chan_r <= pwdata_i[CHAN_W-1:0];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      hit = 1'b1;
      rdata_nxt = '0;
      case (paddr_i)
         OFS_MODE: rdata_nxt = mode_r;
         OFS_TOTAL_LO: rdata_nxt = total_r[31:0];
         OFS_TOTAL_HI: rdata_nxt = total_r[63:32];
         OFS_LOOPS: rdata_nxt = loops_r;
         OFS_SEGLEN: rdata_nxt = seglen_r;
         OFS_CHAN: rdata_nxt[CHAN_W-1:0] = chan_r;
         OFS_CTRL: rdata_nxt = '0;
         OFS_STATUS:
         begin
            rdata_nxt[STAT_RUN_BIT] = (state_r != MSSR_IDLE);
            rdata_nxt[STAT_ARMED_BIT] = (state_r == MSSR_ARMED);
            rdata_nxt[STAT_ERR_BIT] = err_r;
            rdata_nxt[STAT_DATA_BIT] = fifo_valid;
         end
         OFS_SEGCNT: rdata_nxt = segs_r;
         default: hit = 1'b0;
      endcase
   end

   // Read data is captured in the setup phase and stands during access.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prdata_r <= '0;
      end
      else if (psel_i && !penable_i)
      begin
         prdata_r <= pwrite_i ? '0 : rdata_nxt;
      end
   end

   assign prdata_o = prdata_r;
   // Every access completes in its first access cycle, with no wait state.
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         err_r <= 1'b0;
      end
      else if (start_req)
      begin
         err_r <= cfg_bad;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= MSSR_IDLE;
      end
      else if (start_req)
      begin
         // A bad setting refuses the start and leaves the sequencer idle.
         state_r <= cfg_bad ? MSSR_IDLE : MSSR_ARMED;
      end
      // Start is checked first, so it wins when both bits are written.
      else if (stop_req)
      begin
         state_r <= MSSR_IDLE;
      end
      else
      begin
         case (state_r)
            MSSR_ARMED:
            begin
               if (trig_edge)
               begin
                  state_r <= MSSR_PLAY;
               end
            end
            MSSR_PLAY:
            begin
               if (seg_end && is_std)
               begin
                  // A loop count of zero never ends on its own.
                  state_r <= (mem_end && (loops_r != '0)) ?
                             MSSR_IDLE : MSSR_ARMED;
               end
               else if (seg_end)
               begin
                  state_r <= strm_done ? MSSR_IDLE : MSSR_ARMED;
               end
            end
            default: state_r <= MSSR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         idx_r <= '0;
         seg_base_r <= '0;
         segs_r <= '0;
      end
      else if (start_req)
      begin
         idx_r <= '0;
         seg_base_r <= '0;
         segs_r <= '0;
      end
      else if (seg_end)
      begin
         idx_r <= '0;
         // The completed count feeds the streaming total and the segment count readback.
         segs_r <= segs_r + 1'b1;
         seg_base_r <= (is_std && mem_end) ? '0 : next_base;
      end
      else if (step)
      begin
         idx_r <= idx_r + 1'b1;
      end
   end

   // Memory returns data one cycle after the read strobe.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rd_r <= 1'b0;
         rd_lat_r <= 1'b0;
         mem_addr_r <= '0;
      end
      else
      begin
         rd_r <= (state_r == MSSR_PLAY) && is_std && !stop_req &&
                 !start_req;
         rd_lat_r <= rd_r;
         if ((state_r == MSSR_PLAY) && is_std)
         begin
            mem_addr_r <= rd_addr[MEM_AW-1:0];
         end
      end
   end

   assign mem_rd_o = rd_r;
   assign mem_addr_o = mem_addr_r;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sample_r <= '0;
         svalid_r <= 1'b0;
      end
      else
      begin
         // Memory wins when memory and FIFO feed a sample in the same cycle.
         svalid_r <= rd_lat_r | (fifo_take & fifo_valid);
         if (rd_lat_r)
         begin
            sample_r <= mem_rdata_i;
         end
         else if (fifo_take && fifo_valid)
         begin
            sample_r <= fifo_data;
         end
      end
   end

   assign sample_o = sample_r;
   assign sample_valid_o = svalid_r;
   assign armed_o = (state_r == MSSR_ARMED);
endmodule // mssr_top
`default_nettype wire

// file: mssr_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mssr_chk #(
   parameter int unsigned MEM_AW = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [mssr_pkg::APB_AW-1:0] paddr_i,
   input wire logic [mssr_pkg::APB_DW-1:0] pwdata_i,
   input wire logic trigger_i,
   input wire logic mem_rd_o,
   input wire logic [MEM_AW-1:0] mem_addr_o,
   input wire logic [mssr_pkg::SAMPLE_W-1:0] mem_rdata_i,
   input wire logic [mssr_pkg::SAMPLE_W-1:0] sample_o,
   input wire logic sample_valid_o,
   input wire logic armed_o
);
   import mssr_pkg::*;
   logic [31:0] seg_r, tot_r, mode_r, cnt_r;
   wire logic wr_en = psel_i && penable_i && pwrite_i;
   // Shadow copies of the settings that the replay must follow.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         seg_r <= SEGLEN_RST;
         tot_r <= TOTAL_RST[31:0];
         mode_r <= MODE_RST;
      end
      else if (wr_en)
      begin
         if (paddr_i == OFS_SEGLEN) seg_r <= pwdata_i;
         if (paddr_i == OFS_TOTAL_LO) tot_r <= pwdata_i;
         if (paddr_i == OFS_MODE) mode_r <= pwdata_i;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i) cnt_r <= 32'h0;
      else cnt_r <= mem_rd_o ? cnt_r + 32'h1 : 32'h0;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   seg_len_a: assert property ($fell(mem_rd_o) |-> cnt_r == seg_r)
      else $error("read burst length differs from segment length");
   addr_step_a: assert property (mem_rd_o && $past(mem_rd_o)
      |-> mem_addr_o == $past(mem_addr_o) + 1'b1)
      else $error("sample address did not step by one");
   seg_base_a: assert property ($rose(mem_rd_o) |-> mem_addr_o % seg_r == 0)
      else $error("segment does not start on a segment boundary");
   in_mem_a: assert property (mem_rd_o |-> mem_addr_o < tot_r)
      else $error("read beyond the programmed total");
   rd_sample_a: assert property (mem_rd_o |-> ##2
      sample_valid_o && sample_o == $past(mem_rdata_i))
      else $error("memory word not replayed two cycles later");
   play_arm_a: assert property ($rose(mem_rd_o)
      |-> $past(armed_o) || $past(armed_o, 2))
      else $error("segment began without being armed");
   trig_play_a: assert property (armed_o && $rose(trigger_i)
      |-> ##[2:6] !armed_o)
      else $error("trigger while armed did not start a segment");
   std_mode_a: assert property (mem_rd_o |-> mode_r == STD_MULTI_CODE)
      else $error("memory read outside standard mode");
   cover property ($fell(mem_rd_o));
   cover property (sample_valid_o && mode_r == STRM_MULTI_CODE);
   cover property (armed_o && $rose(trigger_i));
endmodule // mssr_chk
`default_nettype wire

// file: mssr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mssr_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [15:0] first_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [15:0] data_o,
   output int sent_o
);
   int seed = 32'hdbd9;
   int rnd = 0;
   wire logic pick = go_i && rnd[1:0] != 2'h0;
   always @(posedge clk_i) rnd <= $random(seed);
   // Words go out in order and are held until the FIFO takes them.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         valid_o <= 1'b0;
         data_o <= 16'h0;
         sent_o <= 0;
      end
      else if (!valid_o || ready_i)
      begin
         valid_o <= pick;
         data_o <= pick ? first_i + 16'(sent_o + 32'(valid_o)) : ~data_o;
         sent_o <= sent_o + 32'(valid_o);
      end
   end
endmodule // mssr_host_model
`default_nettype wire

// file: mssr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mssr_top_tb;
   import mssr_pkg::*;
   logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic trigger_i = 0, go = 0, pready_o, pslverr_o, strm_valid_i;
   logic strm_ready_o, mem_rd_o, sample_valid_o, armed_o, er;
   logic [15:0] paddr_i = 0, first = 0, mem_rdata_i = 0, mem_addr_o;
   logic [15:0] strm_data_i, sample_o;
   logic [31:0] pwdata_i = 0, prdata_o, rd;
   int err_count = 0, n_tests = 0, seed = 32'hdbd9, sent, t;
   logic [15:0] q[$];
   mssr_top #(.MEM_AW(16), .MEM_SAMPLES(64'h400)) i_mssr_top (.clk_i,
      .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .trigger_i, .strm_data_i,
      .strm_valid_i, .strm_ready_o, .mem_rd_o, .mem_addr_o, .mem_rdata_i,
      .sample_o, .sample_valid_o, .armed_o);
   mssr_host_model i_mssr_host_model (.clk_i, .rst_i, .go_i(go),
      .first_i(first), .ready_i(strm_ready_o), .valid_o(strm_valid_i),
      .data_o(strm_data_i), .sent_o(sent));
   function logic [15:0] mval(logic [15:0] a);
      return a ^ 16'h5A5A;
   endfunction
   initial
   begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      mem_rdata_i <= (mem_rd_o === 1'b1) ? mval(mem_addr_o) : ~mem_rdata_i;
      if (sample_valid_o === 1'b1) q.push_back(sample_o);
   end
   task chk(string nm, logic [63:0] seen, logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task apb(logic w, logic [15:0] a, logic [31:0] d);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge clk_i);
   endtask
   task rg(logic [15:0] a, logic [31:0] exp);
      apb(0, a, 0);
      chk("register", rd, exp);
   endtask
   task trig(int n);
      trigger_i <= 1;
      repeat (2 + $unsigned($random(seed)) % 3) @(posedge clk_i);
      trigger_i <= 0;
      t = 0;
      while (q.size() < n && t++ < 400) @(posedge clk_i);
      repeat (6) @(posedge clk_i);
   endtask
   task cmp(logic s, logic [15:0] b);
      chk("count", q.size(), 8);
      for (int i = 0; i < 8 && i < q.size(); i++)
         chk("sample", q[i], s ? mval(b + 16'(i)) : b + 16'(i));
      q.delete();
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      #1000000;
      err_count++;
      report_and_stop;
   end
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rg(OFS_MODE, MODE_RST);
      rg(OFS_TOTAL_LO, TOTAL_RST[31:0]);
      rg(OFS_LOOPS, LOOPS_RST);
      rg(OFS_SEGLEN, SEGLEN_RST);
      rg(OFS_TOTAL_HI, TOTAL_RST[63:32]);
      rg(OFS_CHAN, 32'(CHAN_RST));
      apb(0, 16'h2800, 0);
      chk("unmapped", {er, rd}, 33'h100000000);
      $display("test registers done");
      // Total is a whole multiple of the segment length, both steps of 8.
      apb(1, OFS_MODE, STD_MULTI_CODE);
      apb(1, OFS_TOTAL_LO, 32);
      apb(1, OFS_CTRL, 1);
      chk("armed", armed_o, 1);
      for (int i = 0; i < 4; i++)
      begin
         trig(8);
         cmp(1, 16'(8 * i));
      end
      trig(1);
      chk("after last", q.size(), 0);
      rg(OFS_STATUS, 0);
      rg(OFS_SEGCNT, 4);
      apb(1, OFS_TOTAL_LO, 16);
      apb(1, OFS_LOOPS, 0);
      apb(1, OFS_CTRL, 1);
      for (int i = 0; i < 3; i++)
      begin
         trig(8);
         cmp(1, 16'(8 * (i % 2)));
      end
      rg(OFS_STATUS, 3);
      apb(1, OFS_CTRL, 2);
      rg(OFS_STATUS, 0);
      $display("test standard done");
      apb(1, OFS_CHAN, 3);
      rg(OFS_CHAN, 3);
      apb(1, OFS_TOTAL_LO, 256);
      apb(1, OFS_CTRL, 1);
      rg(OFS_STATUS, 4);
      apb(1, OFS_CHAN, 0);
      apb(1, OFS_MODE, 32'h400);
      apb(1, OFS_CTRL, 1);
      rg(OFS_STATUS, 4);
      $display("test config error done");
      apb(1, OFS_MODE, STRM_MULTI_CODE);
      apb(1, OFS_TOTAL_LO, 32'hFFFFFFF8);
      apb(1, OFS_LOOPS, 2);
      first <= 16'($random(seed));
      go <= 1;
      apb(1, OFS_CTRL, 1);
      t = 0;
      while (strm_ready_o !== 1'b0 && t++ < 300) @(posedge clk_i);
      @(posedge clk_i);
      chk("fifo full", {strm_ready_o, 32'(sent)}, 33'h8);
      rg(OFS_STATUS, 11);
      trig(8);
      cmp(0, first);
      trig(8);
      cmp(0, first + 16'h8);
      trig(1);
      chk("after last", q.size(), 0);
      rg(OFS_SEGCNT, 2);
      apb(1, OFS_LOOPS, 0);
      apb(1, OFS_CTRL, 1);
      for (int i = 0; i < 3; i++)
      begin
         trig(8);
         cmp(0, first + 16'(16 + 8 * i));
      end
      apb(0, OFS_STATUS, 0);
      chk("running", rd[1:0], 2'h3);
      $display("test streaming done");
      report_and_stop;
   end
endmodule // mssr_top_tb
bind mssr_top mssr_chk #(.MEM_AW(MEM_AW)) i_mssr_chk (.clk_i, .rst_i,
   .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .trigger_i,
   .mem_rd_o, .mem_addr_o, .mem_rdata_i, .sample_o, .sample_valid_o,
   .armed_o);
`default_nettype wire
